// [rtl/ubt_baud_timing.v]
/*
 * baud-rate generator and frame timing: base clock select, 8-bit divisor,
 * tx bit pacing with back-to-back gap, rx sampling from start bit.
 * assumes an avalon-mm master on clk_sys and async serial lines on pins.
 */
// Behaviour
// - base clock select in bits 3..0
// - rx samples timed from own rx counter
// - sampling margin of two base clocks
// - tolerated rate band for 11-bit frames
// - back-to-back frames gain two base clocks
// - rx timing restarts at each start bit
// - bit rate equals base clock over 2k
// - rx counter runs one frame then halts
// - tx counter clears per frame, else runs
// - codes 0..10 divide, 11 timer, rest prohibited
`include "ubt_consts.vh"
`default_nettype none
module ubt_baud_timing #(
	parameter PRE_W = 10
) (
	input wire clk_sys,
	input wire rst,
	input wire [`UBT_ADDR_W-1:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output reg [31:0] avs_readdata,
	output reg avs_waitrequest,
	input wire timer_out,
	input wire rx_pin,
	input wire tx_start,
	output reg tx_bit_tick,
	output reg tx_frame_done,
	output reg rx_sample_tick,
	output reg rx_frame_done,
	output reg baud_clk_out
);
	reg [3:0] sel_ff;
	reg [7:0] div_ff;
	reg [2:0] mode_ff;
	reg [PRE_W-1:0] pre_ff;
	reg [PRE_W-1:0] pre_d_ff;
	reg [1:0] rx_sync_ff;
	reg [1:0] tm_sync_ff;
	reg tm_prev_ff;
	reg base_en;
	reg ack_ff;
	// busy flags live with their counters below but feed the status word here
	reg tx_busy_ff;
	reg rx_busy_ff;
	// power gates both directions, so clearing it stops every counter
	wire power = mode_ff[`UBT_MODE_POWER];
	wire tx_on = power & mode_ff[`UBT_MODE_TXE];
	wire rx_on = power & mode_ff[`UBT_MODE_RXE];
	wire bad_sel = sel_ff > `UBT_SEL_TIMER;
	// bus slave: one wait cycle, then ack; unmapped reads give zero
	// readdata is captured on the request edge, so it stands at the ack edge
	always @(posedge clk_sys) begin
		if (rst) begin
			ack_ff <= 1'b0;
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0000_0000;
			sel_ff <= `UBT_RST_SEL;
			div_ff <= `UBT_RST_DIV;
			mode_ff <= 3'h0;
		end else begin
			ack_ff <= (avs_read | avs_write) & ~ack_ff;
			avs_waitrequest <= ~((avs_read | avs_write) & ~ack_ff);
			if (ack_ff & avs_write & avs_byteenable[0]) begin
				case (avs_address)
				`UBT_OFS_CLKSEL: sel_ff <= avs_writedata[`UBT_SEL_MSB:`UBT_SEL_LSB];
				`UBT_OFS_DIVCTL: div_ff <= avs_writedata[7:0]; // below 4 only flagged
				`UBT_OFS_MODE: mode_ff <= avs_writedata[2:0];
				default: ;
				endcase
			end
			if ((avs_read | avs_write) & ~ack_ff) begin
				case (avs_address)
				`UBT_OFS_CLKSEL: avs_readdata <= {28'h000_0000, sel_ff};
				`UBT_OFS_DIVCTL: avs_readdata <= {24'h00_0000, div_ff};
				`UBT_OFS_MODE: avs_readdata <= {29'h0000_0000, mode_ff};
				`UBT_OFS_STATUS: avs_readdata <= {27'h000_0000, bad_sel, div_ff < `UBT_DIV_MIN,
					rx_busy_ff, tx_busy_ff, baud_clk_out};
				default: avs_readdata <= 32'h0000_0000;
				endcase
			end
		end
	end
	// prescaler and pin synchronisers; first stages only feed second stages
	always @(posedge clk_sys) begin
		if (rst | ~power) begin
			pre_ff <= {PRE_W{1'b0}};
			pre_d_ff <= {PRE_W{1'b0}};
			rx_sync_ff <= 2'h3;
			tm_sync_ff <= 2'h0;
			tm_prev_ff <= 1'b0;
		end else begin
			pre_ff <= pre_ff + {{(PRE_W-1){1'b0}}, 1'b1};
			pre_d_ff <= pre_ff;
			rx_sync_ff <= {rx_sync_ff[0], rx_pin};
			tm_sync_ff <= {tm_sync_ff[0], timer_out};
			tm_prev_ff <= tm_sync_ff[1];
		end
	end
	// base clock enable: every cycle for code 0, rising edge of prescaler bit (code-1), or timer edge
	integer i;
	always @* begin
		base_en = 1'b0;
		if (power) begin
			if (sel_ff == 4'h0)
				base_en = 1'b1;
			else if (sel_ff <= `UBT_SEL_MAX_POW) begin
				for (i = 1; i <= PRE_W; i = i + 1)
					if (sel_ff == i[3:0])
						base_en = pre_ff[i-1] & ~pre_d_ff[i-1];
			end else if (sel_ff == `UBT_SEL_TIMER)
				base_en = tm_sync_ff[1] & ~tm_prev_ff;
		end
	end
	// free-running divider: k base clocks per half bit
	reg [7:0] bcnt_ff;
	always @(posedge clk_sys) begin
		if (rst | ~power) begin
			bcnt_ff <= 8'h00;
			baud_clk_out <= 1'b0;
		end else if (base_en) begin
			if (bcnt_ff + 8'h01 >= div_ff) begin
				bcnt_ff <= 8'h00;
				baud_clk_out <= ~baud_clk_out;
			end else
				bcnt_ff <= bcnt_ff + 8'h01;
		end
	end
	// tx counter: bit time is 2k base clocks; 2-clock gap between frames
	reg [8:0] tcnt_ff;
	reg [3:0] tbit_ff;
	reg [1:0] tgap_ff;
	reg tx_pend_ff;
	wire [8:0] bit_len = {div_ff, 1'b0};
	always @(posedge clk_sys) begin
		tx_bit_tick <= 1'b0;
		tx_frame_done <= 1'b0;
		if (rst | ~tx_on) begin
			tcnt_ff <= 9'h000;
			tbit_ff <= 4'h0;
			tgap_ff <= 2'h0;
			tx_busy_ff <= 1'b0;
			tx_pend_ff <= 1'b0;
		end else begin
			// a start during the gap is queued too, otherwise it would be lost
			if (tx_start & (tx_busy_ff | (tgap_ff != 2'h0)))
				tx_pend_ff <= 1'b1;
			if (tx_start & ~tx_busy_ff & (tgap_ff == 2'h0)) begin
				tcnt_ff <= 9'h000; // first start clears the counter
				tbit_ff <= 4'h0;
				tx_busy_ff <= 1'b1;
			end else if (base_en) begin
				if (tgap_ff != 2'h0) begin
					tgap_ff <= tgap_ff - 2'h1;
					if (tgap_ff == 2'h1) begin
						tcnt_ff <= 9'h000;
						tbit_ff <= 4'h0;
						tx_busy_ff <= 1'b1;
					end
				end else if (tcnt_ff + 9'h001 >= bit_len) begin
					tcnt_ff <= 9'h000;
					if (tx_busy_ff) begin
						tx_bit_tick <= 1'b1;
						if (tbit_ff == `UBT_FRAME_BITS - 4'h1) begin
							tx_frame_done <= 1'b1;
							tx_busy_ff <= 1'b0;
							if (tx_pend_ff | tx_start) begin
								tgap_ff <= `UBT_GAP_BASE;
								tx_pend_ff <= 1'b0;
							end
						end else
							tbit_ff <= tbit_ff + 4'h1;
					end
				end else
					tcnt_ff <= tcnt_ff + 9'h001; // idle keeps counting
			end
		end
	end
	// rx counter: starts on start bit, samples at mid-bit, halts after frame
	reg [8:0] rcnt_ff;
	reg [3:0] rbit_ff;
	wire rx_low = ~rx_sync_ff[1];
	always @(posedge clk_sys) begin
		rx_sample_tick <= 1'b0;
		rx_frame_done <= 1'b0;
		if (rst | ~rx_on) begin
			rcnt_ff <= 9'h000;
			rbit_ff <= 4'h0;
			rx_busy_ff <= 1'b0;
		end else if (~rx_busy_ff) begin
			if (rx_low) begin
				rx_busy_ff <= 1'b1;
				rcnt_ff <= 9'h000;
				rbit_ff <= 4'h0;
			end
		end else if (base_en) begin
			// mid-bit sample at k leaves >=2 base clock margin for k>=4
			if (rcnt_ff + 9'h001 == {1'b0, div_ff}) begin
				rx_sample_tick <= 1'b1;
				if (rbit_ff == `UBT_FRAME_BITS - 4'h1) begin
					rx_frame_done <= 1'b1;
					rx_busy_ff <= 1'b0;
				end
			end
			if (rcnt_ff + 9'h001 >= bit_len) begin
				rcnt_ff <= 9'h000;
				rbit_ff <= rbit_ff + 4'h1;
			end else
				rcnt_ff <= rcnt_ff + 9'h001;
		end
	end
endmodule // ubt_baud_timing
`default_nettype wire

// [rtl/ubt_consts.vh]
/*
 * constants for the baud timing block: register map, fields, reset values, counts.
 * assumes inclusion by bare name from rtl design files only.
 */
`ifndef UBT_CONSTS_VH
`define UBT_CONSTS_VH
`define UBT_ADDR_W 4
`define UBT_OFS_CLKSEL 4'h0
`define UBT_OFS_DIVCTL 4'h4
`define UBT_OFS_MODE 4'h8
`define UBT_OFS_STATUS 4'hC
`define UBT_SEL_LSB 0
`define UBT_SEL_MSB 3
`define UBT_SEL_MAX_POW 4'hA
`define UBT_SEL_TIMER 4'hB
`define UBT_RST_SEL 4'h0
`define UBT_RST_DIV 8'hFF
`define UBT_MODE_POWER 0
`define UBT_MODE_TXE 1
`define UBT_MODE_RXE 2
`define UBT_DIV_MIN 8'h04
`define UBT_FRAME_BITS 4'hB
`define UBT_GAP_BASE 2'h2
`endif

// [tb/ubt_chk.sv]
/* checker: bus answer timing, tick spacing, frame end pulses.
   assumes binding onto ubt_baud_timing and k of 4 or more */
`default_nettype none
module ubt_chk (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire logic tx_bit_tick,
	input wire logic tx_frame_done,
	input wire logic rx_sample_tick,
	input wire logic rx_frame_done
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// bus answer comes within two edges and lasts one cycle
	AST_ANSWER: assert property ((avs_read || avs_write) |-> ##[0:2] !avs_waitrequest)
		else $error("bus answer late");
	AST_WAITONE: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("ack long");
	// a bit is 2k base clocks, so never under eight cycles
	AST_TXBIT: assert property (tx_bit_tick |=> !tx_bit_tick [*7])
		else $error("tx bit short");
	AST_RXSMP: assert property (rx_sample_tick |=> !rx_sample_tick [*3])
		else $error("rx sample early");
	// frame end rides on the last bit tick itself
	AST_TXEND: assert property (tx_frame_done |-> tx_bit_tick)
		else $error("tx end off tick");
	AST_RXEND: assert property (rx_frame_done |-> rx_sample_tick)
		else $error("rx end off sample");
	AST_TXONE: assert property (tx_frame_done |=> !tx_frame_done [*8])
		else $error("tx end twice");
	AST_RXONE: assert property (rx_frame_done |=> !rx_frame_done [*8])
		else $error("rx end twice");
	AST_CV_TX: cover property (tx_frame_done);
	AST_CV_RX: cover property (rx_frame_done);
	AST_CV_WR: cover property (avs_write && !avs_waitrequest);
endmodule // ubt_chk
bind ubt_baud_timing ubt_chk i_chk (.clk_sys, .rst, .avs_read, .avs_write, .avs_waitrequest,
	.tx_bit_tick, .tx_frame_done, .rx_sample_tick, .rx_frame_done);
`default_nettype wire

// [tb/ubt_remote.sv]
/* remote sender on the receive line.
   assumes the bench gives bit period and gap in clk_sys cycles */
`default_nettype none
module ubt_remote (
	input wire logic clk_sys,
	output logic rx_pin
);
	timeunit 1ns;
	timeprecision 1ns;
	initial rx_pin = 1'b1;
	// start, nine random bits, stop, then idle gap; rate kept exact
	task automatic send(input int per, input int gap);
		logic [10:0] f;
		f = {1'b1, 9'($urandom), 1'b0};
		for (int i = 0; i < 11; i++) begin
			rx_pin <= f[i];
			repeat (per) @(posedge clk_sys);
		end
		repeat (gap) @(posedge clk_sys);
	endtask
endmodule // ubt_remote
`default_nettype wire

// [tb/ubt_baud_timing_tb_top.sv]
/* bench: register setup, tx bit and frame timing, rx sample counts.
   assumes select code 0 means clk_sys itself as base clock */
`default_nettype none
module ubt_baud_timing_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys, rst, avs_read, avs_write, timer_out, rx_pin, tx_start, avs_waitrequest;
	logic tx_bit_tick, tx_frame_done, rx_sample_tick, rx_frame_done, baud_clk_out;
	logic [3:0] avs_address, avs_byteenable;
	logic [31:0] avs_writedata, avs_readdata, q;
	int bad_count, cmp_count, cyc, t0, k, s, n, tdiv;
	ubt_baud_timing i_dut (.clk_sys, .rst, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .timer_out,
		.rx_pin, .tx_start, .tx_bit_tick, .tx_frame_done, .rx_sample_tick,
		.rx_frame_done, .baud_clk_out);
	ubt_remote i_rem (.clk_sys, .rx_pin);
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	// stand-in for the external timer: high three cycles, low three
	always @(posedge clk_sys) begin
		tdiv <= (tdiv + 1) % 6;
		timer_out <= (tdiv < 3);
	end
	// cycle count doubles as hang limit
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc > 60000) begin
			bad_count++;
			print_verdict();
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	// one bus access held until waitrequest seen low
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk_sys);
	endtask
	function automatic int bitc(int kk, int ss);
		return (2 * kk) << ss;
	endfunction
	task automatic pulse_start;
		tx_start <= 1'b1;
		@(posedge clk_sys);
		tx_start <= 1'b0;
	endtask
	task automatic rx_count;
		n = 0;
		do begin
			@(posedge clk_sys);
			if (rx_sample_tick === 1'b1) n++;
		end while (rx_frame_done !== 1'b1);
		chk(n, 11);
	endtask
	// cycles between two changes of the serial clock output
	task automatic half_per;
		logic b;
		b = baud_clk_out;
		do @(posedge clk_sys); while (baud_clk_out === b);
		t0 = cyc;
		b = baud_clk_out;
		do @(posedge clk_sys); while (baud_clk_out === b);
		n = cyc - t0;
	endtask
	// changes of the serial clock output over forty cycles
	task automatic count_toggles;
		logic b;
		n = 0;
		b = baud_clk_out;
		repeat (40) begin
			@(posedge clk_sys);
			if (baud_clk_out !== b) n++;
			b = baud_clk_out;
		end
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		void'($urandom(32'h16e7_6a66));
		{avs_read, avs_write, tx_start, avs_address, avs_writedata} = '0;
		avs_byteenable = 4'hF;
		rst = 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		bus(0, 4'h4, 0);
		chk(q, 32'h0000_00FF);
		bus(0, 4'h2, 0);
		chk(q, 32'h0000_0000);
		// illegal divisor and prohibited code raise their status flags
		bus(1, 4'h4, 2);
		bus(1, 4'h0, 12);
		bus(0, 4'hC, 0);
		chk(q, 32'h0000_0018);
		// prohibited code with power on gives no base clock at all
		bus(1, 4'h8, 1);
		count_toggles();
		chk(n, 0);
		// timer output as base clock: one rising edge every six cycles
		bus(1, 4'h4, 4);
		bus(1, 4'h0, 11);
		half_per();
		chk(n, 4 * 6);
		// first pass is the smallest legal divisor
		for (int i = 0; i < 3; i++) begin
			s = (i == 0) ? 0 : $urandom % 3;
			k = (i == 0) ? 4 : 4 + $urandom % 12;
			bus(1, 4'h8, 0);
			bus(1, 4'h0, ($urandom << 4) | s);
			bus(0, 4'h0, 0);
			chk(q, s);
			bus(1, 4'h4, k);
			bus(1, 4'h8, 7);
			bus(0, 4'h8, 0);
			chk(q, 32'h0000_0007);
			half_per();
			chk(n, k << s);
			pulse_start();
			repeat (3) @(posedge clk_sys);
			pulse_start();
			do @(posedge clk_sys); while (tx_bit_tick !== 1'b1);
			t0 = cyc;
			do @(posedge clk_sys); while (tx_bit_tick !== 1'b1);
			chk(cyc - t0, bitc(k, s));
			do @(posedge clk_sys); while (tx_frame_done !== 1'b1);
			t0 = cyc;
			do @(posedge clk_sys); while (tx_frame_done !== 1'b1);
			chk(cyc - t0, (22 * k + 2) << s);
			fork
				begin
					i_rem.send(bitc(k, s), 2 << s);
					i_rem.send(bitc(k, s), 8);
				end
				begin
					rx_count();
					rx_count();
				end
			join
		end
		print_verdict();
	end
endmodule // ubt_baud_timing_tb_top
`default_nettype wire
